// [rtl/frs_pkg.sv]
/*
 * Constants for the flash reset and deep-sleep controller.
 * Assumes a 100 MHz core clock; all pin timing is counted in its cycles.
 */
`default_nettype none
package frs_pkg;
    // Clock period, ns
    localparam int unsigned CLK_PERIOD_NS          = 10;
    // Reset pulse minimum, ns
    localparam int unsigned RESET_PULSE_MIN_NS     = 100;
    localparam int unsigned RESET_PULSE_MIN_CYC    = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Reset abort latency maximum, us
    localparam int unsigned RESET_ABORT_LATENCY_US = 25;
    localparam int unsigned RESET_ABORT_LATENCY_CYC = (RESET_ABORT_LATENCY_US * 1000) / CLK_PERIOD_NS;
    // Cycles of pin sync and state pipeline around the abort count
    localparam int unsigned ABORT_LAG_CYC          = 5;
    // Supply valid to reset release, ns
    localparam int unsigned SUPPLY_TO_RELEASE_NS   = 300;
    // Sleep pulse minimum, ns
    localparam int unsigned SLEEP_PULSE_MIN_NS     = 100;
    localparam int unsigned SLEEP_PULSE_MIN_CYC    = (SLEEP_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Sleep exit to select low, us
    localparam int unsigned SLEEP_EXIT_TO_SELECT_US = 75;
    localparam int unsigned SLEEP_EXIT_TO_SELECT_CYC =
        (SLEEP_EXIT_TO_SELECT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Status register value after reset or deep sleep
    localparam logic [15:0] STATUS_DEFAULT         = 16'h0080;
    // Extended configuration field positions
    localparam int unsigned ECR_SLEEP_EN_BIT       = 15;
    localparam int unsigned ECR_SLEEP_POL_BIT      = 14;
    // Status error bits cleared by deep sleep
    localparam logic [15:0] STATUS_ERR_MASK        = 16'h007F;
    // Controller states
    typedef enum logic [4:0] {
        ST_RESET   = 5'h01,
        ST_ABORT   = 5'h02,
        ST_ACTIVE  = 5'h04,
        ST_SLEEP   = 5'h08,
        ST_WAKE    = 5'h10
    } frs_state_type;
endpackage
`default_nettype wire

// [rtl/frs_cnt.sv]
/*
 * Down-counter used to measure minimum and maximum delays.
 * Assumes load and count come from the same clock domain.
 */
`default_nettype none
module frs_cnt #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             i_clk,    // Core clock
    input  wire logic             i_srst,   // Synchronous reset
    input  wire logic             i_load,   // Load start value
    input  wire logic [WIDTH-1:0] i_value,  // Start value
    output logic                  o_zero    // Count has expired
);
    logic [WIDTH-1:0] cnt_q;  // Current count
    logic [WIDTH-1:0] cnt_d;  // Next count

    // Refuse a counter too narrow to count
    if (WIDTH < 2) begin
        $error("WIDTH too small");
    end

    // Load or decrement toward zero
    always_comb begin
        cnt_d = cnt_q;
        if (i_load) begin
            cnt_d = i_value;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - WIDTH'(1);
        end
    end

    // Register the count
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_zero = (cnt_q == '0);
endmodule
`default_nettype wire

// [rtl/frs_ctrl.sv]
/*
 * Reset and deep-sleep controller of a parallel flash device.
 * Assumes pin inputs are asynchronous to I_CLOCK and that the array
 * engine reports program, erase and suspend state on the same clock.
 */
// Notes on behaviour
// - Reset low: ignore inputs, float outputs
// - Reset during program/erase completes within 25 us
// - Idle reset completes within minimum pulse
// - Leave reset: read-array mode, status 0080h
// - Reset aborts program or erase
// - Quiet address after read enters standby
// - Deep sleep needs enable bit, deselect, pin
// - Deep sleep aborts program or erase
// - Deep sleep discards suspended operation
// - Deep sleep ignores all but pin, reset
// - Deep sleep keeps config, resets status
// - Pin release exits sleep after delay
// - Bit 14 zero makes sleep pin active low
`default_nettype none
module frs_ctrl
    import frs_pkg::*;
#(
    parameter int unsigned ABORT_CYC = RESET_ABORT_LATENCY_CYC,  // Worst-case abort length
    parameter int unsigned WAKE_CYC  = SLEEP_EXIT_TO_SELECT_CYC  // Sleep exit delay
) (
    input  wire logic        I_CLOCK,             // Core clock
    input  wire logic        I_SRST,              // Synchronous reset
    input  wire logic        I_RESET_N,           // Reset pin, active low
    input  wire logic        I_CHIP_SELECT_N,     // Chip select pin, active low
    input  wire logic        I_DEEP_SLEEP_PIN,    // Deep-sleep pin, raw level
    input  wire logic        I_ADDR_ACTIVITY,     // Address lines toggled this cycle
    input  wire logic        I_READ_DONE,         // Array read finished
    input  wire logic        I_PROG_ERASE_BUSY,   // Program or erase running
    input  wire logic        I_SUSPENDED,         // Program or erase suspended
    input  wire logic        I_STATUS_SET_VALID,  // Engine writes status
    input  wire logic [15:0] I_STATUS_SET,        // Status value from engine
    input  wire logic [15:0] I_EXTENDED_CONFIG_REG, // Extended configuration
    output logic             O_INPUTS_ENABLE,     // Address and control accepted
    output logic             O_OUTPUTS_ENABLE_N,  // Low lets data and wait drive
    output logic             O_ABORT_OPERATION,   // Abort program or erase
    output logic             O_DISCARD_SUSPEND,   // Drop suspended operation
    output logic             O_READ_ARRAY_MODE,   // Force asynchronous read-array
    output logic             O_STANDBY,           // Automatic power saving
    output logic             O_DEEP_SLEEP,        // In deep power-down
    output logic             O_READY,             // Accepting operations
    output logic [15:0]      O_STATUS             // Status register
);
    // Two-flop synchronisers for pins
    logic [2:0] pin_meta_q;  // First stage
    logic [2:0] pin_sync_q;  // Second stage
    logic       rst_n_s;     // Synced reset pin
    logic       cs_n_s;      // Synced chip select
    logic       sleep_s;     // Synced sleep pin level

    logic          sleep_asserted;  // Sleep pin at its active level
    logic          sleep_enable;    // Deep sleep permitted
    frs_state_type state_q;         // Current state
    frs_state_type state_d;         // Next state
    logic          load_q;          // Counter load pulse
    logic          load_d;
    logic [31:0]   load_val_q;      // Counter start value
    logic [31:0]   load_val_d;
    logic          cnt_zero;        // Delay expired
    logic          started_q;       // Counter has been loaded for this phase
    logic          started_d;
    logic [15:0]   status_q;        // Status register
    logic [15:0]   status_d;
    logic          standby_q;       // Standby flag
    logic          standby_d;
    logic          rdm_q;           // Read-array pulse
    logic          rdm_d;
    logic          abort_q;         // Abort pulse
    logic          abort_d;
    logic          discard_q;       // Discard pulse
    logic          discard_d;

    // Refuse delays that the counter pipeline cannot serve
    if (WAKE_CYC < 1 || ABORT_CYC <= ABORT_LAG_CYC) begin
        $error("Delay counts too small");
    end

    // Pin synchronisers
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            pin_meta_q <= 3'h2;  // Reset pin asserted, deselected
            pin_sync_q <= 3'h2;
        end else begin
            pin_meta_q <= {I_DEEP_SLEEP_PIN, I_CHIP_SELECT_N, I_RESET_N};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign rst_n_s = pin_sync_q[0];
    assign cs_n_s  = pin_sync_q[1];
    assign sleep_s = pin_sync_q[2];
    // Polarity follows bit 14; zero means active low
    assign sleep_asserted = I_EXTENDED_CONFIG_REG[ECR_SLEEP_POL_BIT] ? sleep_s : ~sleep_s;
    // All four entry conditions at once, in any order of arrival
    assign sleep_enable = I_EXTENDED_CONFIG_REG[ECR_SLEEP_EN_BIT] & rst_n_s & cs_n_s & sleep_asserted;

    // Shared delay counter, cycles of the reference clock
    frs_cnt #(
        .WIDTH   (32)
    ) u_cnt (
        .i_clk   (I_CLOCK),
        .i_srst  (I_SRST),
        .i_load  (load_q),
        .i_value (load_val_q),
        .o_zero  (cnt_zero)
    );

    // Next-state logic
    always_comb begin
        state_d    = state_q;
        load_d     = 1'b0;
        load_val_d = load_val_q;
        started_d  = started_q;
        status_d   = status_q;
        standby_d  = standby_q;
        rdm_d      = 1'b0;
        abort_d    = 1'b0;
        discard_d  = 1'b0;
        if (!rst_n_s && state_q != ST_RESET && state_q != ST_ABORT) begin
            // Reset pin asserted from any other state
            started_d = 1'b0;
            standby_d = 1'b0;
            if (I_PROG_ERASE_BUSY) begin
                abort_d    = 1'b1;
                load_d     = 1'b1;
                load_val_d = ABORT_CYC - ABORT_LAG_CYC;  // Pipeline counted in the bound
                state_d    = ST_ABORT;
            end else begin
                state_d = ST_RESET;  // Idle reset done at once
            end
        end else begin
            unique case (state_q)
                ST_RESET: begin
                    // Release: read-array mode and default status
                    if (rst_n_s) begin
                        rdm_d    = 1'b1;
                        status_d = STATUS_DEFAULT;
                        state_d  = ST_ACTIVE;
                    end
                end
                ST_ABORT: begin
                    // Abort finishes within the latency bound
                    if (cnt_zero && !load_q) begin
                        state_d = ST_RESET;
                    end
                end
                ST_ACTIVE: begin
                    if (sleep_enable) begin
                        // Abort running work and drop suspend on entry
                        abort_d   = I_PROG_ERASE_BUSY;
                        discard_d = I_SUSPENDED;
                        // Status back to default, errors cleared
                        status_d  = STATUS_DEFAULT & ~STATUS_ERR_MASK;
                        standby_d = 1'b0;
                        state_d   = ST_SLEEP;
                    end else begin
                        if (I_STATUS_SET_VALID) begin
                            status_d = I_STATUS_SET;
                        end
                        // Quiet address after a read: standby
                        if (I_ADDR_ACTIVITY) begin
                            standby_d = 1'b0;  // Address moved: leave standby
                        end else if (I_READ_DONE) begin
                            standby_d = 1'b1;  // Read done, address quiet
                        end
                    end
                end
                ST_SLEEP: begin
                    // Only sleep pin and reset matter here
                    if (!sleep_asserted) begin
                        load_d     = 1'b1;
                        load_val_d = WAKE_CYC;
                        started_d  = 1'b1;
                        state_d    = ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    // Exit delay before standby and operations
                    if (started_q && cnt_zero && !load_q) begin
                        started_d = 1'b0;
                        standby_d = 1'b1;
                        state_d   = ST_ACTIVE;
                    end
                end
                default: begin
                    state_d = ST_RESET;
                end
            endcase
        end
    end

    // Register state
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            state_q    <= ST_RESET;
            load_q     <= 1'b0;
            load_val_q <= 32'h0;
            started_q  <= 1'b0;
            status_q   <= STATUS_DEFAULT;
            standby_q  <= 1'b0;
            rdm_q      <= 1'b0;
            abort_q    <= 1'b0;
            discard_q  <= 1'b0;
        end else begin
            state_q    <= state_d;
            load_q     <= load_d;
            load_val_q <= load_val_d;
            started_q  <= started_d;
            status_q   <= status_d;
            standby_q  <= standby_d;
            rdm_q      <= rdm_d;
            abort_q    <= abort_d;
            discard_q  <= discard_d;
        end
    end

    // Output flops; inputs masked and outputs floated in reset
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            O_INPUTS_ENABLE    <= 1'b0;
            O_OUTPUTS_ENABLE_N <= 1'b1;
            O_DEEP_SLEEP       <= 1'b0;
            O_READY            <= 1'b0;
        end else begin
            O_INPUTS_ENABLE    <= (state_d == ST_ACTIVE);
            O_OUTPUTS_ENABLE_N <= (state_d != ST_ACTIVE) | cs_n_s;
            O_DEEP_SLEEP       <= (state_d == ST_SLEEP) | (state_d == ST_WAKE);
            O_READY            <= (state_d == ST_ACTIVE);
        end
    end

    assign O_ABORT_OPERATION = abort_q;
    assign O_DISCARD_SUSPEND = discard_q;
    assign O_READ_ARRAY_MODE = rdm_q;
    assign O_STANDBY         = standby_q;
    assign O_STATUS          = status_q;
endmodule
`default_nettype wire

// [tb/frs_ctrl_sva.sv]
/* Checker for the flash reset and deep-sleep controller ports.
   Assumes the bench binds it into frs_ctrl by name. */
`default_nettype none
module frs_ctrl_sva
    import frs_pkg::*;
#(
    parameter int unsigned ABORT_CYC = 20, // Abort length
    parameter int unsigned WAKE_CYC  = 30  // Sleep exit delay
) (
    input wire logic        I_CLOCK,
    input wire logic        I_SRST,
    input wire logic        I_RESET_N,
    input wire logic        I_CHIP_SELECT_N,
    input wire logic        I_DEEP_SLEEP_PIN,
    input wire logic        I_ADDR_ACTIVITY,
    input wire logic        I_READ_DONE,
    input wire logic        I_PROG_ERASE_BUSY,
    input wire logic        I_SUSPENDED,
    input wire logic        I_STATUS_SET_VALID,
    input wire logic [15:0] I_STATUS_SET,
    input wire logic [15:0] I_EXTENDED_CONFIG_REG,
    input wire logic        O_INPUTS_ENABLE,
    input wire logic        O_OUTPUTS_ENABLE_N,
    input wire logic        O_ABORT_OPERATION,
    input wire logic        O_DISCARD_SUSPEND,
    input wire logic        O_READ_ARRAY_MODE,
    input wire logic        O_STANDBY,
    input wire logic        O_DEEP_SLEEP,
    input wire logic        O_READY,
    input wire logic [15:0] O_STATUS
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_SRST);
    // Sleep pin sits at its asserted level
    wire logic act = (I_DEEP_SLEEP_PIN == I_EXTENDED_CONFIG_REG[ECR_SLEEP_POL_BIT]);
    int unsigned wake_q; // Cycles in deep sleep since the pin was released
    // Count the exit delay
    always_ff @(posedge I_CLOCK) begin
        wake_q <= (I_SRST || !O_DEEP_SLEEP || act) ? 0 : wake_q + 1;
    end
    reset_float_a: assert property (!I_RESET_N [*4] |-> O_OUTPUTS_ENABLE_N && !O_INPUTS_ENABLE)
        else $error("outputs not floated in reset");
    idle_reset_a: assert property ($fell(I_RESET_N) && O_READY && !I_PROG_ERASE_BUSY |-> ##[1:10] !O_READY)
        else $error("idle reset too slow");
    abort_start_a: assert property ($fell(I_RESET_N) && O_READY && I_PROG_ERASE_BUSY |-> ##[1:6] O_ABORT_OPERATION)
        else $error("reset did not abort");
    exit_default_a: assert property (O_READ_ARRAY_MODE |-> O_STATUS == STATUS_DEFAULT)
        else $error("status not default on reset exit");
    sleep_gate_a: assert property ($rose(O_DEEP_SLEEP) |-> I_EXTENDED_CONFIG_REG[15] && I_CHIP_SELECT_N && I_RESET_N)
        else $error("sleep entered without its conditions");
    sleep_enter_a: assert property ($rose(act) && O_READY && I_EXTENDED_CONFIG_REG[15]
        && I_CHIP_SELECT_N && I_RESET_N |-> ##[1:6] O_DEEP_SLEEP)
        else $error("sleep not entered");
    sleep_status_a: assert property ($rose(O_DEEP_SLEEP) |-> ##[0:1] O_STATUS == STATUS_DEFAULT)
        else $error("status not reset in sleep");
    sleep_frozen_a: assert property (O_DEEP_SLEEP && $past(O_DEEP_SLEEP) |-> $stable(O_STATUS) && O_OUTPUTS_ENABLE_N)
        else $error("sleep did not ignore inputs");
    sleep_discard_a: assert property ($rose(O_DEEP_SLEEP) && I_SUSPENDED
        |-> ##[0:1] (O_DISCARD_SUSPEND || $past(O_DISCARD_SUSPEND)))
        else $error("suspend not discarded");
    wake_min_a: assert property ($fell(O_DEEP_SLEEP) |-> wake_q >= WAKE_CYC)
        else $error("sleep exit too early");
    wake_max_a: assert property (wake_q <= WAKE_CYC + 8)
        else $error("sleep exit too late");
    standby_a: assert property (O_READY && I_READ_DONE && !I_ADDR_ACTIVITY ##1 !I_ADDR_ACTIVITY
        |-> ##[0:2] O_STANDBY)
        else $error("standby not entered");
    abort_c: cover property (O_ABORT_OPERATION);
    discard_c: cover property (O_DISCARD_SUSPEND);
    wake_c: cover property ($fell(O_DEEP_SLEEP));
endmodule
`default_nettype wire

// [tb/frs_host.sv]
/* Host model driving reset, chip select and deep-sleep pins.
   Assumes the bench asks for pin changes by level requests. */
`default_nettype none
module frs_host
    import frs_pkg::*;
#(
    parameter int unsigned WAKE = SLEEP_EXIT_TO_SELECT_CYC // Wait after sleep exit
) (
    input  wire logic i_clk,       // Core clock
    input  wire logic i_rst_req,   // Hold device in reset
    input  wire logic i_sleep_req, // Ask for deep sleep
    input  wire logic i_sel_req,   // Ask to select
    input  wire logic i_pol,       // Asserted sleep pin level
    output var logic  o_reset_n,   // Reset pin
    output var logic  o_cs_n,      // Chip select pin
    output var logic  o_sleep_pin  // Deep-sleep pin
);
    timeunit 1ns;
    timeprecision 100ps;
    int unsigned hold_q = 30;   // Cycles before the next change, 300 ns at power-up
    logic        rst_q  = 1'b0; // Reset level, low over power-up
    logic        slp_q  = 1'b0; // Sleep asserted
    // Pins idle until the first falling edge
    initial begin
        o_reset_n = 1'b0;
        o_cs_n = 1'b1;
        o_sleep_pin = 1'b1;
    end
    // Decide at the rising edge, one change per minimum interval
    always @(posedge i_clk) begin
        if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end else if (rst_q == i_rst_req) begin
            rst_q <= !i_rst_req;
            hold_q <= RESET_PULSE_MIN_CYC;
        end else if (slp_q != i_sleep_req) begin
            slp_q <= i_sleep_req;
            hold_q <= i_sleep_req ? SLEEP_PULSE_MIN_CYC : WAKE;
        end
    end
    // Drive pins after the falling edge; select stays high around sleep
    always @(negedge i_clk) begin
        o_reset_n <= rst_q;
        o_sleep_pin <= slp_q ? i_pol : !i_pol;
        o_cs_n <= !(i_sel_req && rst_q && !slp_q && hold_q == 0);
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
/* Bench for the flash reset and deep-sleep controller.
   Assumes the host model frs_host and the checker frs_ctrl_sva. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import frs_pkg::*;
    localparam int ABT = 20; // Shortened abort
    localparam int WK  = 30; // Shortened wake
    logic clk = 0, srst = 1, rst_req = 0, slp_req = 0, sel_req = 0;
    logic addr = 0, rdone = 0, busy = 0, susp = 0, sv = 0;
    logic [15:0] sset = 16'h0000, extended_config_reg = 16'h0000, status;
    logic reset_n, cs_n, pin, ien, oen_n, abort, disc, rdm, stby, dslp, ready;
    int miscompares = 0, checks = 0, cyc = 0, n_abort = 0, n_disc = 0, n_rdm = 0;
    frs_ctrl #(.ABORT_CYC(ABT), .WAKE_CYC(WK)) u_frs_ctrl (.I_CLOCK(clk), .I_SRST(srst),
        .I_RESET_N(reset_n), .I_CHIP_SELECT_N(cs_n), .I_DEEP_SLEEP_PIN(pin), .I_ADDR_ACTIVITY(addr),
        .I_READ_DONE(rdone), .I_PROG_ERASE_BUSY(busy), .I_SUSPENDED(susp), .I_STATUS_SET_VALID(sv),
        .I_STATUS_SET(sset), .I_EXTENDED_CONFIG_REG(extended_config_reg), .O_INPUTS_ENABLE(ien), .O_OUTPUTS_ENABLE_N(oen_n),
        .O_ABORT_OPERATION(abort), .O_DISCARD_SUSPEND(disc), .O_READ_ARRAY_MODE(rdm), .O_STANDBY(stby),
        .O_DEEP_SLEEP(dslp), .O_READY(ready), .O_STATUS(status));
    frs_host #(.WAKE(WK)) u_frs_host (.i_clk(clk), .i_rst_req(rst_req), .i_sleep_req(slp_req),
        .i_sel_req(sel_req), .i_pol(extended_config_reg[14]), .o_reset_n(reset_n), .o_cs_n(cs_n), .o_sleep_pin(pin));
    always #5 clk = ~clk;
    // Count pulses where they are settled and cut a hang short
    always @(negedge clk) begin
        n_abort += (abort === 1'b1);
        n_disc += (disc === 1'b1);
        n_rdm += (rdm === 1'b1);
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    // Wait up to n cycles for ready (or deep sleep) to reach v
    task automatic wait_on(input bit s, input logic v, input int n, output int k);
        for (k = 0; k < n && (s ? dslp : ready) !== v; k++) @(negedge clk);
    endtask
    // One engine status write
    task automatic wr_status(input logic [15:0] v);
        sv = 1;
        sset = v;
        @(negedge clk);
        sv = 0;
        @(negedge clk);
    endtask
    task automatic t_standby();
        addr = 1;
        @(negedge clk);
        rdone = 1;
        addr = 0;
        @(negedge clk);
        rdone = 0;
        repeat (3) @(negedge clk);
        chk("standby", 1, stby);
        $display("done standby");
    endtask
    task automatic t_reset_idle();
        int k, r;
        wr_status(16'h1234);
        chk("status write", 16'h1234, status);
        rst_req = 1;
        wait_on(0, 0, 14, k);
        chk("idle reset time", 1, k <= RESET_PULSE_MIN_CYC + 1);
        wr_status(16'h5555);
        chk("outputs float", 1, oen_n);
        chk("inputs off", 0, ien);
        r = n_rdm;
        rst_req = 0;
        wait_on(0, 1, 30, k);
        @(negedge clk);
        chk("status default", STATUS_DEFAULT, status);
        chk("read array", r + 1, n_rdm);
        $display("done idle reset");
    endtask
    task automatic t_reset_busy();
        int k, a;
        sel_req = 1;
        busy = 1;
        // Host keeps select high until its reset hold has run out
        repeat (RESET_PULSE_MIN_CYC + 6) @(negedge clk);
        chk("outputs drive", 0, oen_n);
        a = n_abort;
        rst_req = 1;
        repeat (12) @(negedge clk);
        chk("abort pulses", a + 1, n_abort);
        chk("outputs float", 1, oen_n);
        busy = 0;
        rst_req = 0;
        sel_req = 0;
        // Released early, so ready shows when the abort bound ends
        wait_on(0, 1, 30, k);
        chk("abort time", 1, 12 + k <= ABT + 6);
        chk("ready after abort", 1, ready);
        $display("done busy reset");
    endtask
    task automatic t_sleep(input logic pol);
        int k, d, a;
        // Settle the new polarity through the pin sync before enabling sleep
        extended_config_reg = {1'b0, pol, 14'h0000};
        repeat (3) @(negedge clk);
        extended_config_reg[15] = 1'b1;
        wr_status(16'h00FF);
        susp = 1;
        busy = pol;
        d = n_disc;
        a = n_abort;
        slp_req = 1;
        wait_on(1, 1, 20, k);
        repeat (2) @(negedge clk);
        chk("deep sleep", 1, dslp);
        chk("sleep status", STATUS_DEFAULT, status);
        chk("discard", d + 1, n_disc);
        chk("sleep abort", a + pol, n_abort);
        addr = 1;
        wr_status(16'h1234);
        chk("inputs ignored", STATUS_DEFAULT, status);
        {susp, busy, addr, slp_req} = 4'h0;
        wait_on(1, 0, WK + 40, k);
        chk("wake delay", 1, k >= WK);
        chk("ready after wake", 1, ready & stby);
        $display("done sleep");
    endtask
    task automatic t_no_sleep();
        extended_config_reg = 16'h4000;
        slp_req = 1;
        repeat (20) @(negedge clk);
        chk("no sleep unless enabled", 0, dslp);
        slp_req = 0;
        repeat (WK + 15) @(negedge clk);
        $display("done sleep disabled");
    endtask
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Reset, then run every scenario
    initial begin
        int k;
        repeat (10) @(negedge clk);
        srst = 0;
        wait_on(0, 1, 80, k);
        chk("first status", STATUS_DEFAULT, status);
        t_standby();
        t_reset_idle();
        t_reset_busy();
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_no_sleep();
        give_verdict();
    end
endmodule
bind frs_ctrl frs_ctrl_sva #(.ABORT_CYC(ABORT_CYC), .WAKE_CYC(WAKE_CYC)) u_frs_ctrl_sva (
    .I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_RESET_N(I_RESET_N), .I_CHIP_SELECT_N(I_CHIP_SELECT_N),
    .I_DEEP_SLEEP_PIN(I_DEEP_SLEEP_PIN), .I_ADDR_ACTIVITY(I_ADDR_ACTIVITY), .I_READ_DONE(I_READ_DONE),
    .I_PROG_ERASE_BUSY(I_PROG_ERASE_BUSY), .I_SUSPENDED(I_SUSPENDED), .I_STATUS_SET_VALID(I_STATUS_SET_VALID),
    .I_STATUS_SET(I_STATUS_SET), .I_EXTENDED_CONFIG_REG(I_EXTENDED_CONFIG_REG),
    .O_INPUTS_ENABLE(O_INPUTS_ENABLE), .O_OUTPUTS_ENABLE_N(O_OUTPUTS_ENABLE_N),
    .O_ABORT_OPERATION(O_ABORT_OPERATION), .O_DISCARD_SUSPEND(O_DISCARD_SUSPEND),
    .O_READ_ARRAY_MODE(O_READ_ARRAY_MODE), .O_STANDBY(O_STANDBY), .O_DEEP_SLEEP(O_DEEP_SLEEP),
    .O_READY(O_READY), .O_STATUS(O_STATUS));
`default_nettype wire
